// *** core/aas_pkg.sv ***
// aas_pkg: register map, field layout, reset values and operation codes
// for the add/and/shift datapath slice.
// assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.
package aas_pkg;

  // byte offsets
  localparam int ADDR_W = 10;
  localparam logic [9:0] OFS_CMD = 10'h000;
  localparam logic [9:0] OFS_ACC = 10'h004;
  localparam logic [9:0] OFS_STATUS = 10'h008;
  localparam logic [9:0] OFS_PTR0 = 10'h00C;
  localparam logic [9:0] OFS_PTR1 = 10'h010;
  localparam logic [9:0] OFS_FILE_BASE = 10'h200;
  localparam int FILE_BASE_BIT = 9;

  // file register window
  localparam int FILE_DEPTH = 128;
  localparam int FILE_AW = 7;

  // command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DEST_BIT = 3;
  localparam int CMD_SEL_BIT = 4;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_LIT_LSB = 16;
  localparam logic [3:0] CMD_FULL_BE = 4'hF;

  // status fields
  localparam int STAT_C_BIT = 0;
  localparam int STAT_DC_BIT = 1;
  localparam int STAT_Z_BIT = 2;

  // pointer literal width
  localparam int PTR_LIT_W = 6;

  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] FILE_RST = 8'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [31:0] CMD_RST = 32'h0000_0000;
  localparam logic FLAG_RST = 1'b0;

  typedef enum logic [2:0] {
    OP_POINTER_LITERAL_ADD = 3'h0,
    OP_LITERAL_AND = 3'h1,
    OP_LITERAL_ADD = 3'h2,
    OP_FILE_AND = 3'h3,
    OP_FILE_ADD = 3'h4,
    OP_ARITH_RIGHT_SHIFT = 3'h5,
    OP_FILE_ADD_WITH_CARRY = 3'h6,
    OP_NONE = 3'h7
  } aas_op_e;

endpackage

// *** core/aas_alu.sv ***
// aas_alu: combinational result, flag and write-enable logic for one operation.
// assumes operands are stable for the cycle in which the command is taken.
`timescale 1ns/1ps
module aas_alu
  import aas_pkg::*;
(
  // operation
  input wire aas_op_e op,
  input wire logic dest,
  // operands
  input wire logic [7:0] acc,
  input wire logic [7:0] fval,
  input wire logic [7:0] lit,
  input wire logic carry_in,
  input wire logic [15:0] ptr_in,
  // results
  output logic [7:0] res,
  output logic [15:0] ptr_out,
  output logic c_out,
  output logic dc_out,
  output logic z_out,
  // enables
  output logic upd_c,
  output logic upd_dc,
  output logic upd_z,
  output logic wr_acc,
  output logic wr_file,
  output logic wr_ptr
);

  always_comb begin
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] opnd;
    logic cin;
    opnd = (op == OP_LITERAL_ADD) ? lit : fval;
    cin = (op == OP_FILE_ADD_WITH_CARRY) & carry_in;
    sum = {1'b0, acc} + {1'b0, opnd} + {8'h00, cin};
    nib = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
    res = 8'h00;
    ptr_out = ptr_in;
    c_out = sum[8];
    dc_out = nib[4];
    upd_c = 1'b0;
    upd_dc = 1'b0;
    upd_z = 1'b0;
    wr_acc = 1'b0;
    wr_file = 1'b0;
    wr_ptr = 1'b0;
    case (op)
      OP_POINTER_LITERAL_ADD: begin
        // 16-bit add drops the carry, so the pointer wraps both ways
        ptr_out = ptr_in + {{(16 - PTR_LIT_W){lit[PTR_LIT_W-1]}}, lit[PTR_LIT_W-1:0]};
        wr_ptr = 1'b1;
      end
      OP_LITERAL_AND: begin
        res = acc & lit;
        upd_z = 1'b1;
        wr_acc = 1'b1;
      end
      OP_LITERAL_ADD: begin
        res = sum[7:0];
        {upd_c, upd_dc, upd_z} = 3'h7;
        wr_acc = 1'b1;
      end
      OP_FILE_AND: begin
        res = acc & fval;
        upd_z = 1'b1;
        {wr_file, wr_acc} = {dest, ~dest};
      end
      OP_FILE_ADD, OP_FILE_ADD_WITH_CARRY: begin
        res = sum[7:0];
        {upd_c, upd_dc, upd_z} = 3'h7;
        {wr_file, wr_acc} = {dest, ~dest};
      end
      OP_ARITH_RIGHT_SHIFT: begin
        res = {fval[7], fval[7:1]};
        c_out = fval[0];
        {upd_c, upd_z} = 2'h3;
        {wr_file, wr_acc} = {dest, ~dest};
      end
      default: begin
        res = 8'h00;
      end
    endcase
    z_out = (res == 8'h00);
  end

endmodule // aas_alu

// *** core/aas_core.sv ***
// aas_core: accumulator, flags, two pointer pairs and a 128-byte file
// behind an Avalon-MM slave; a full-word command write runs one operation.
// assumes a master that holds each request until waitrequest is low.
//
// Functional notes
// - pointer add sign-extends a 6-bit literal into the selected pair; no flags change
// - pointer pair is 16 bits and wraps modulo 65536 either way
// - literal AND writes acc AND literal to the accumulator, zero flag only
// - literal add writes acc plus literal to accumulator, updating carry, half-carry, zero
// - file AND combines accumulator with addressed file byte, zero flag only
// - destination bit 0 sends result to accumulator, 1 back to the file byte
// - file add sums accumulator and file byte, routed, updating carry, half-carry, zero
// - arithmetic right shift keeps bit 7, old bit 0 into carry, updates carry and zero
// - add with carry sums accumulator, file byte and carry, routed, all three flags
//
// The Avalon-MM slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module aas_core
  import aas_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // datapath state
  output logic [7:0] acc_value,
  output logic carry_flag,
  output logic half_carry_flag,
  output logic zero_flag,
  output logic [15:0] ptr0_value,
  output logic [15:0] ptr1_value
);

  function automatic logic in_file_window(input logic [ADDR_W-1:0] a);
    return a[FILE_BASE_BIT];
  endfunction

  function automatic logic [FILE_AW-1:0] file_index(input logic [ADDR_W-1:0] a);
    return a[FILE_AW+1:2];
  endfunction

  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] cmd_q;
  logic [7:0] acc_q;
  logic c_q;
  logic dc_q;
  logic z_q;
  logic [15:0] ptr_q [2];
  logic [7:0] file_mem [FILE_DEPTH];

  logic req;
  logic wr_fire;
  logic rd_take;
  logic [ADDR_W-1:0] word_addr;
  logic cmd_exec;
  aas_op_e cmd_op;
  logic cmd_dest;
  logic cmd_sel;
  logic [FILE_AW-1:0] cmd_addr;
  logic [7:0] cmd_lit;
  logic [7:0] alu_res;
  logic [15:0] alu_ptr;
  logic alu_c;
  logic alu_dc;
  logic alu_z;
  logic upd_c;
  logic upd_dc;
  logic upd_z;
  logic wr_acc;
  logic wr_file;
  logic wr_ptr;

  // one wait cycle per access keeps read data registered
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign wr_fire = avs_write & ack_q;
  assign rd_take = avs_read & ~ack_q;
  assign word_addr = {avs_address[ADDR_W-1:2], 2'b00};

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // partial writes to the command word are dropped, not half-executed
  assign cmd_exec = wr_fire & (word_addr == OFS_CMD) & (avs_byteenable == CMD_FULL_BE);
  assign cmd_op = aas_op_e'(avs_writedata[CMD_OP_LSB+2:CMD_OP_LSB]);
  assign cmd_dest = avs_writedata[CMD_DEST_BIT];
  assign cmd_sel = avs_writedata[CMD_SEL_BIT];
  assign cmd_addr = avs_writedata[CMD_ADDR_LSB+FILE_AW-1:CMD_ADDR_LSB];
  assign cmd_lit = avs_writedata[CMD_LIT_LSB+7:CMD_LIT_LSB];

  aas_alu i_aas_alu (
    .op(cmd_op),
    .dest(cmd_dest),
    .acc(acc_q),
    .fval(file_mem[cmd_addr]),
    .lit(cmd_lit),
    .carry_in(c_q),
    .ptr_in(ptr_q[cmd_sel]),
    .res(alu_res),
    .ptr_out(alu_ptr),
    .c_out(alu_c),
    .dc_out(alu_dc),
    .z_out(alu_z),
    .upd_c(upd_c),
    .upd_dc(upd_dc),
    .upd_z(upd_z),
    .wr_acc(wr_acc),
    .wr_file(wr_file),
    .wr_ptr(wr_ptr)
  );

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_q <= CMD_RST;
    end else if (cmd_exec) begin
      cmd_q <= avs_writedata;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_q <= ACC_RST;
    end else if (cmd_exec && wr_acc) begin
      acc_q <= alu_res;
    end else if (wr_fire && word_addr == OFS_ACC && avs_byteenable[0]) begin
      acc_q <= avs_writedata[7:0];
    end
  end

  // a command moves flags only when the operation says so; pointer add touches none
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      c_q <= FLAG_RST;
      dc_q <= FLAG_RST;
      z_q <= FLAG_RST;
    end else if (cmd_exec) begin
      if (upd_c) c_q <= alu_c;
      if (upd_dc) dc_q <= alu_dc;
      if (upd_z) z_q <= alu_z;
    end else if (wr_fire && word_addr == OFS_STATUS && avs_byteenable[0]) begin
      c_q <= avs_writedata[STAT_C_BIT];
      dc_q <= avs_writedata[STAT_DC_BIT];
      z_q <= avs_writedata[STAT_Z_BIT];
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_ptr
    localparam logic [ADDR_W-1:0] OFS = (g == 0) ? OFS_PTR0 : OFS_PTR1;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
        ptr_q[g] <= PTR_RST;
      end else if (cmd_exec && wr_ptr && cmd_sel == 1'(g)) begin
        ptr_q[g] <= alu_ptr;
      end else if (wr_fire && word_addr == OFS) begin
        if (avs_byteenable[0]) ptr_q[g][7:0] <= avs_writedata[7:0];
        if (avs_byteenable[1]) ptr_q[g][15:8] <= avs_writedata[15:8];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        file_mem[i] <= FILE_RST;
      end
    end else if (cmd_exec && wr_file) begin
      file_mem[cmd_addr] <= alu_res;
    end else if (wr_fire && in_file_window(avs_address) && avs_byteenable[0]) begin
      file_mem[file_index(avs_address)] <= avs_writedata[7:0];
    end
  end

  // read data is latched during the wait cycle and held until the next read
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_take) begin
      if (in_file_window(avs_address)) begin
        rdata_q <= {24'h00_0000, file_mem[file_index(avs_address)]};
      end else begin
        case (word_addr)
          OFS_CMD: rdata_q <= cmd_q;
          OFS_ACC: rdata_q <= {24'h00_0000, acc_q};
          OFS_STATUS: rdata_q <= {29'h0000_0000, z_q, dc_q, c_q};
          OFS_PTR0: rdata_q <= {16'h0000, ptr_q[0]};
          OFS_PTR1: rdata_q <= {16'h0000, ptr_q[1]};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign avs_readdata = rdata_q;
  assign acc_value = acc_q;
  assign carry_flag = c_q;
  assign half_carry_flag = dc_q;
  assign zero_flag = z_q;
  assign ptr0_value = ptr_q[0];
  assign ptr1_value = ptr_q[1];

  // checking: snapshot of operands at each executed command
  logic h_valid;
  aas_op_e h_op;
  logic h_dest;
  logic h_sel;
  logic h_c;
  logic h_dc;
  logic h_z;
  logic [7:0] h_acc;
  logic [7:0] h_f;
  logic [7:0] h_lit;
  logic [FILE_AW-1:0] h_addr;
  logic [15:0] h_ptr;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      h_valid <= 1'b0;
      h_op <= OP_NONE;
      {h_dest, h_sel, h_c, h_dc, h_z} <= 5'h00;
      {h_acc, h_f, h_lit} <= 24'h00_0000;
      h_addr <= '0;
      h_ptr <= 16'h0000;
    end else begin
      h_valid <= cmd_exec;
      h_op <= cmd_op;
      {h_dest, h_sel, h_c, h_dc, h_z} <= {cmd_dest, cmd_sel, c_q, dc_q, z_q};
      {h_acc, h_f, h_lit} <= {acc_q, file_mem[cmd_addr], cmd_lit};
      h_addr <= cmd_addr;
      h_ptr <= ptr_q[cmd_sel];
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_wait_phase;
    req && avs_waitrequest;
  endsequence
  sequence s_answer_phase;
    !avs_waitrequest || !req;
  endsequence

  chk_bus_answer: assert property (s_wait_phase |=> s_answer_phase)
    else $error("bus request waited more than one cycle");
  chk_ptr_flags_hold: assert property (h_valid && h_op == OP_POINTER_LITERAL_ADD
    |-> {c_q, dc_q, z_q} == {h_c, h_dc, h_z})
    else $error("pointer add changed a flag");
  chk_ptr_wrap_sum: assert property (h_valid && h_op == OP_POINTER_LITERAL_ADD
    |-> ptr_q[h_sel] == 16'(h_ptr + {{10{h_lit[5]}}, h_lit[5:0]}))
    else $error("pointer add result wrong");
  chk_land_result: assert property (h_valid && h_op == OP_LITERAL_AND
    |-> acc_q == (h_acc & h_lit) && c_q == h_c && dc_q == h_dc)
    else $error("literal and result or flags wrong");
  chk_ladd_sum: assert property (h_valid && h_op == OP_LITERAL_ADD
    |-> {c_q, acc_q} == 9'({1'b0, h_acc} + {1'b0, h_lit}))
    else $error("literal add sum or carry wrong");
  chk_fand_zero: assert property (h_valid && h_op == OP_FILE_AND
    |-> z_q == ((h_acc & h_f) == 8'h00) && c_q == h_c)
    else $error("file and flags wrong");
  chk_dest_route: assert property (h_valid && h_op inside {OP_FILE_AND, OP_FILE_ADD,
    OP_ARITH_RIGHT_SHIFT, OP_FILE_ADD_WITH_CARRY}
    |-> (h_dest ? acc_q == h_acc : file_mem[h_addr] == h_f))
    else $error("result went to the wrong destination");
  chk_fadd_sum: assert property (h_valid && h_op == OP_FILE_ADD && !h_dest
    |-> {c_q, acc_q} == 9'({1'b0, h_acc} + {1'b0, h_f}))
    else $error("file add sum or carry wrong");
  chk_shift_msb: assert property (h_valid && h_op == OP_ARITH_RIGHT_SHIFT && h_dest
    |-> file_mem[h_addr] == {h_f[7], h_f[7:1]} && c_q == h_f[0])
    else $error("arithmetic shift wrong");
  chk_addc_sum: assert property (h_valid && h_op == OP_FILE_ADD_WITH_CARRY && !h_dest
    |-> {c_q, acc_q} == 9'({1'b0, h_acc} + {1'b0, h_f} + {8'h00, h_c}))
    else $error("add with carry wrong");
  chk_zero_flag: assert property (h_valid && h_op == OP_LITERAL_ADD
    |-> z_q == (acc_q == 8'h00))
    else $error("zero flag disagrees with result");
  chk_half_carry: assert property (h_valid && h_op == OP_FILE_ADD
    |-> dc_q == (5'({1'b0, h_acc[3:0]} + {1'b0, h_f[3:0]}) > 5'h0F))
    else $error("half carry wrong");

endmodule // aas_core

// *** test/aas_bus_master.sv ***
// aas_bus_master: avalon-mm master standing in for the host that drives the core.
// assumes each transfer is started right after a rising edge of sys_clk.
`timescale 1ns/1ps
module aas_bus_master
  import aas_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // avalon-mm master side
  output logic [ADDR_W-1:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // status
  output logic timed_out
);
  initial begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
    timed_out = 1'b0;
  end

  // holds the request until waitrequest is seen low; bounded so a dead slave ends the run
  task automatic xfer(input logic rd, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
    int n;
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= d;
    avs_byteenable <= be;
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 20) timed_out <= 1'b1;
    // one idle edge so no strobe is assigned twice in a time step
    @(posedge sys_clk);
  endtask
endmodule // aas_bus_master

// *** test/add_and_shift_alu_ops_bench.sv ***
// add_and_shift_alu_ops_bench: self-checking run of every operation over the bus.
// assumes aas_core with one wait cycle per transfer and the bus master model.
`timescale 1ns/1ps
module add_and_shift_alu_ops_bench;
  import aas_pkg::*;
  logic sys_clk, sys_rst;
  logic [ADDR_W-1:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, timed_out, carry_flag, half_carry_flag, zero_flag;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [7:0] acc_value;
  logic [15:0] ptr0_value, ptr1_value;
  int error_cnt = 0;
  int comparisons = 0;

  aas_core i_aas_core (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .acc_value(acc_value), .carry_flag(carry_flag),
    .half_carry_flag(half_carry_flag), .zero_flag(zero_flag), .ptr0_value(ptr0_value),
    .ptr1_value(ptr1_value));
  aas_bus_master i_aas_bus_master (.sys_clk(sys_clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .timed_out(timed_out));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic print_verdict;
    $display("mismatches %0d, checks %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic rd, input logic [9:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    i_aas_bus_master.xfer(rd, a, d, be, q);
    if (timed_out === 1'b1) begin
      error_cnt++;
      $display("BAD bus_wait expected 0 seen 1");
      print_verdict();
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, CMD_FULL_BE, q);
  endtask

  task automatic rd_chk(input string name, input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b1, a, 32'h0000_0000, CMD_FULL_BE, q);
    check(name, q, exp);
  endtask

  function automatic logic [31:0] cmd(aas_op_e op, logic dest, logic sel, logic [6:0] f,
                                      logic [7:0] k);
    return {8'h00, k, 1'b0, f, 3'b000, sel, dest, op};
  endfunction

  function automatic logic [9:0] fa(logic [6:0] f);
    return OFS_FILE_BASE + {1'b0, f, 2'b00};
  endfunction

  task automatic exec(aas_op_e op, logic dest, logic sel, logic [6:0] f, logic [7:0] k);
    wr(OFS_CMD, cmd(op, dest, sel, f, k));
  endtask

  task automatic test_reset;
    rd_chk("acc_rst", OFS_ACC, 32'h0000_0000);
    rd_chk("status_rst", OFS_STATUS, 32'h0000_0000);
    rd_chk("ptr1_rst", OFS_PTR1, 32'h0000_0000);
    rd_chk("file_rst", fa(7'h7F), 32'h0000_0000);
    rd_chk("unmapped", 10'h014, 32'h0000_0000);
  endtask

  task automatic test_literal;
    logic [31:0] q;
    wr(OFS_ACC, 32'h0000_008F);
    // partial lanes must not run the command
    bus(1'b0, OFS_CMD, cmd(OP_LITERAL_ADD, 1'b0, 1'b0, 7'h00, 8'h01), 4'h1, q);
    rd_chk("acc_hold", OFS_ACC, 32'h0000_008F);
    exec(OP_LITERAL_ADD, 1'b0, 1'b0, 7'h00, 8'h71);
    rd_chk("ladd_acc", OFS_ACC, 32'h0000_0000);
    rd_chk("ladd_flags", OFS_STATUS, 32'h0000_0007);
    wr(OFS_STATUS, 32'h0000_0003);
    wr(OFS_ACC, 32'h0000_00F0);
    exec(OP_LITERAL_AND, 1'b0, 1'b0, 7'h00, 8'h3C);
    check("land_port", {24'h0, acc_value}, 32'h0000_0030);
    rd_chk("land_flags", OFS_STATUS, 32'h0000_0003);
    exec(OP_LITERAL_AND, 1'b0, 1'b0, 7'h00, 8'h0F);
    rd_chk("land_zero", OFS_STATUS, 32'h0000_0007);
  endtask

  task automatic test_file;
    wr(fa(7'h7F), 32'h0000_000F);
    wr(OFS_ACC, 32'h0000_0001);
    wr(OFS_STATUS, 32'h0000_0000);
    exec(OP_FILE_ADD, 1'b1, 1'b0, 7'h7F, 8'h00);
    rd_chk("fadd_file", fa(7'h7F), 32'h0000_0010);
    rd_chk("fadd_acc", OFS_ACC, 32'h0000_0001);
    rd_chk("fadd_flags", OFS_STATUS, 32'h0000_0002);
    exec(OP_FILE_AND, 1'b0, 1'b0, 7'h7F, 8'h00);
    rd_chk("fand_acc", OFS_ACC, 32'h0000_0000);
    rd_chk("fand_flags", OFS_STATUS, 32'h0000_0006);
    wr(OFS_STATUS, 32'h0000_0001);
    wr(OFS_ACC, 32'h0000_00FF);
    exec(OP_FILE_ADD_WITH_CARRY, 1'b0, 1'b0, 7'h7F, 8'h00);
    rd_chk("addc_acc", OFS_ACC, 32'h0000_0010);
    rd_chk("addc_flags", OFS_STATUS, 32'h0000_0003);
    rd_chk("addc_file", fa(7'h7F), 32'h0000_0010);
    // plain file add into the accumulator, no carry in
    exec(OP_FILE_ADD, 1'b0, 1'b0, 7'h7F, 8'h00);
    rd_chk("fadd_acc_dest", OFS_ACC, 32'h0000_0020);
    rd_chk("fadd_acc_flags", OFS_STATUS, 32'h0000_0000);
    rd_chk("fadd_file_kept", fa(7'h7F), 32'h0000_0010);
  endtask

  task automatic test_shift;
    wr(fa(7'h03), 32'h0000_0081);
    wr(OFS_STATUS, 32'h0000_0002);
    exec(OP_ARITH_RIGHT_SHIFT, 1'b1, 1'b0, 7'h03, 8'h00);
    rd_chk("asr_file", fa(7'h03), 32'h0000_00C0);
    rd_chk("asr_flags", OFS_STATUS, 32'h0000_0003);
    wr(fa(7'h04), 32'h0000_0001);
    wr(OFS_STATUS, 32'h0000_0000);
    exec(OP_ARITH_RIGHT_SHIFT, 1'b0, 1'b0, 7'h04, 8'h00);
    rd_chk("asr_acc", OFS_ACC, 32'h0000_0000);
    rd_chk("asr_zero", OFS_STATUS, 32'h0000_0005);
  endtask

  task automatic test_pointer;
    wr(OFS_PTR0, 32'h0000_FFFF);
    exec(OP_POINTER_LITERAL_ADD, 1'b0, 1'b0, 7'h00, 8'h01);
    check("ptr0_wrap", {16'h0, ptr0_value}, 32'h0000_0000);
    exec(OP_POINTER_LITERAL_ADD, 1'b0, 1'b1, 7'h00, 8'h20);
    rd_chk("ptr1_neg", OFS_PTR1, 32'h0000_FFE0);
    exec(OP_POINTER_LITERAL_ADD, 1'b0, 1'b0, 7'h00, 8'h1F);
    rd_chk("ptr0_max", OFS_PTR0, 32'h0000_001F);
    rd_chk("ptr_flags", OFS_STATUS, 32'h0000_0005);
    check("flag_ports", {29'h0, zero_flag, half_carry_flag, carry_flag}, 32'h0000_0005);
    check("ptr1_port", {16'h0, ptr1_value}, 32'h0000_FFE0);
  endtask

  // the spare opcode is stored but must leave every register alone
  task automatic test_no_op;
    exec(OP_NONE, 1'b1, 1'b1, 7'h04, 8'hFF);
    rd_chk("none_acc", OFS_ACC, 32'h0000_0000);
    rd_chk("none_flags", OFS_STATUS, 32'h0000_0005);
    rd_chk("none_ptr1", OFS_PTR1, 32'h0000_FFE0);
    rd_chk("none_file", fa(7'h04), 32'h0000_0001);
    rd_chk("cmd_readback", OFS_CMD, cmd(OP_NONE, 1'b1, 1'b1, 7'h04, 8'hFF));
  endtask

  initial begin
    sys_rst = 1'b1;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    test_reset();
    test_literal();
    test_file();
    test_shift();
    test_pointer();
    test_no_op();
    print_verdict();
  end
endmodule // add_and_shift_alu_ops_bench
